// *** duc_consts.svh ***
// constants of the converter control core: offsets, fields, resets, timing
`ifndef DUC_CONSTS_SVH
`define DUC_CONSTS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define DUC_NCH           4
`define DUC_DW            10
`define DUC_NGP           12
`define DUC_PW            16
`define DUC_AW            8

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DUC_OFF_DATA0     8'h00
`define DUC_OFF_SYNC      8'h10
`define DUC_OFF_CLEAR     8'h14
`define DUC_OFF_CONFIG    8'h18
`define DUC_OFF_POWER     8'h1C
`define DUC_OFF_RESET     8'h20
`define DUC_OFF_GDIR      8'h24
`define DUC_OFF_GOUT      8'h28
`define DUC_OFF_GIN       8'h2C
`define DUC_OFF_STATUS    8'h30
`define DUC_OFF_CLRV0     8'h40

// ****************************************************************
// fields and reset values
// ****************************************************************
`define DUC_LOAD_BIT      11
`define DUC_RESET_KEY     16'h6600
`define DUC_POWER_RST     16'h0000
`define DUC_RESP_OKAY     2'h0
`define DUC_RESP_SLVERR   2'h2

// ****************************************************************
// timing
// ****************************************************************
`define DUC_LOCK_NS       200000
`define DUC_CLK_NS        5
`define DUC_LOCK_CYCLES   ((`DUC_LOCK_NS + `DUC_CLK_NS - 1) / `DUC_CLK_NS)

`endif

// *** duc_pkg.sv ***
// types of the converter control core
package duc_pkg;
  `include "duc_consts.svh"

  // write channel progress, one-hot
  typedef enum logic [1:0] {
    DUC_WR_IDLE = 2'b01,
    DUC_WR_RESP = 2'b10
  } duc_wr_t;

  // read channel progress, one-hot
  typedef enum logic [1:0] {
    DUC_RD_IDLE = 2'b01,
    DUC_RD_RESP = 2'b10
  } duc_rd_t;

  typedef logic [`DUC_DW-1:0] duc_code_t;

  // whole state of the core apart from the lockout timer
  typedef struct packed {
    duc_code_t [`DUC_NCH-1:0] data;     // pending channel codes
    duc_code_t [`DUC_NCH-1:0] latch;    // codes in the channel latches
    duc_code_t [`DUC_NCH-1:0] clrval;   // preset codes for clear
    duc_code_t [`DUC_NCH-1:0] dac_out;  // codes driven to the outputs
    logic [`DUC_NCH-1:0]      pend;     // written since last load
    logic [`DUC_NCH-1:0]      sync;     // synchronous mode per channel
    logic [`DUC_NCH-1:0]      clr;      // clear state per channel
    logic [`DUC_PW-1:0]       power;    // analog block enables
    logic [`DUC_NGP-1:0]      gdir;     // 1 = pin drives
    logic [`DUC_NGP-1:0]      gout;     // pin output levels
    logic [`DUC_NGP-1:0]      gin;      // captured pin levels
    logic                     aw_have;  // write address held
    logic                     w_have;   // write data held
    logic [`DUC_AW-1:0]       awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    duc_wr_t                  wst;
    logic [1:0]               bresp;
    logic                     awready;
    logic                     wready;
    logic                     arready;
    duc_rd_t                  rst;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } duc_state_t;
endpackage : duc_pkg

// *** duc_lockout.sv ***
// communication lockout timer after power-up and software reset
`timescale 1ns/1ps
`include "duc_consts.svh"
module duc_lockout #(
  parameter int unsigned LOCK_CYCLES = `DUC_LOCK_CYCLES
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // control
  input  wire logic start,
  // status
  output logic      busy
);
  import duc_pkg::*;

  localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);

  // counter and busy flag travel together
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
  } duc_lock_t;

  duc_lock_t st_reg;   // registered state
  duc_lock_t st_next;  // next state

  // ****************************************************************
  // next state
  // ****************************************************************
  // busy from reset release: the host must not talk during power-up either
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt  = '0;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == CW'(LOCK_CYCLES - 1)) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{cnt: '0, busy: 1'b1};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
endmodule : duc_lockout

// *** duc_top.sv ***
// converter control core: channel latches, clear, pins, reset lockout
`timescale 1ns/1ps
`include "duc_consts.svh"
module duc_top #(
  parameter int unsigned LOCK_CYCLES = `DUC_LOCK_CYCLES
) (
  // clock, reset, enable
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  // axi4-lite write address and data
  input  wire logic [`DUC_AW-1:0]           s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // axi4-lite read
  input  wire logic [`DUC_AW-1:0]           s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // channel codes and power enables to the analog side
  output duc_pkg::duc_code_t [`DUC_NCH-1:0] channel_analog_output,
  output logic [`DUC_PW-1:0]                power_ctrl,
  // general-purpose pins
  input  wire logic [`DUC_NGP-1:0]          general_purpose_pin_i,
  output logic [`DUC_NGP-1:0]               general_purpose_pin_o,
  output logic [`DUC_NGP-1:0]               general_purpose_pin_oe,
  // lockout status
  output logic                              lockout_busy
);
  import duc_pkg::*;

  duc_state_t          st_reg;    // registered state
  duc_state_t          st_next;   // next state
  logic                soft_rst;  // reset key accepted this cycle
  logic                trig;      // load trigger this cycle
  logic                wr_go;     // a write is carried out this cycle
  logic [`DUC_AW-1:0]  wr_addr;   // address of that write
  logic [31:0]         wr_val;    // data merged under the strobes
  logic [31:0]         wr_mask;   // byte-lane mask
  logic                busy;      // lockout running

  // ****************************************************************
  // address decode helpers
  // ****************************************************************
  // data and preset registers sit in two strides of four words
  function automatic logic is_mapped(input logic [`DUC_AW-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int c = 0; c < `DUC_NCH; c++) begin
      if (a == `DUC_OFF_DATA0 + `DUC_AW'(4 * c)) hit = 1'b1;
      if (a == `DUC_OFF_CLRV0 + `DUC_AW'(4 * c)) hit = 1'b1;
    end
    case (a)
      `DUC_OFF_SYNC, `DUC_OFF_CLEAR, `DUC_OFF_CONFIG, `DUC_OFF_POWER,
      `DUC_OFF_RESET, `DUC_OFF_GDIR, `DUC_OFF_GOUT, `DUC_OFF_GIN,
      `DUC_OFF_STATUS: hit = 1'b1;
      default: ;
    endcase
    return hit;
  endfunction : is_mapped

  // read-back value; trigger and key registers read as zero
  function automatic logic [31:0] reg_read(input duc_state_t s,
                                           input logic [`DUC_AW-1:0] a,
                                           input logic b);
    logic [31:0] v;
    v = '0;
    for (int c = 0; c < `DUC_NCH; c++) begin
      if (a == `DUC_OFF_DATA0 + `DUC_AW'(4 * c))
        v = 32'(s.latch[c]);
      if (a == `DUC_OFF_CLRV0 + `DUC_AW'(4 * c)) v = 32'(s.clrval[c]);
    end
    case (a)
      `DUC_OFF_SYNC:   v = 32'(s.sync);
      `DUC_OFF_CLEAR:  v = 32'(s.clr);
      `DUC_OFF_POWER:  v = 32'(s.power);
      `DUC_OFF_GDIR:   v = 32'(s.gdir);
      `DUC_OFF_GOUT:   v = 32'(s.gout);
      `DUC_OFF_GIN:    v = 32'(s.gin);
      `DUC_OFF_STATUS: v = 32'(b);
      default: ;
    endcase
    return v;
  endfunction : reg_read

  // ****************************************************************
  // lockout timer
  // ****************************************************************
  duc_lockout #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lockout (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (soft_rst),
    .busy    (busy)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next  = st_reg;
    soft_rst = 1'b0;
    trig     = 1'b0;
    // address and data are taken in either order and held
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    wr_go   = st_next.aw_have && st_next.w_have &&
              (st_reg.wst == DUC_WR_IDLE);
    wr_addr = st_next.awaddr;
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{st_next.wstrb[b]}};
    end
    // lanes left out keep the read-back value, or the pending code for a channel data register
    wr_val = (reg_read(st_reg, wr_addr, busy) & ~wr_mask) |
             (st_next.wdata & wr_mask);
    for (int c = 0; c < `DUC_NCH; c++) begin
      if (wr_addr == `DUC_OFF_DATA0 + `DUC_AW'(4 * c))
        wr_val[`DUC_DW-1:0] = (st_reg.data[c] & ~wr_mask[`DUC_DW-1:0]) |
                              (st_next.wdata[`DUC_DW-1:0] &
                               wr_mask[`DUC_DW-1:0]);
    end
    // carry out a complete write
    if (wr_go) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.wst     = DUC_WR_RESP;
      st_next.bresp   = `DUC_RESP_OKAY;
      if (busy || !is_mapped(wr_addr)) begin
        // a write during lockout, or to an unmapped offset, is refused and has no effect
        st_next.bresp = `DUC_RESP_SLVERR;
      end else begin
        for (int c = 0; c < `DUC_NCH; c++) begin
          if (wr_addr == `DUC_OFF_DATA0 + `DUC_AW'(4 * c)) begin
            st_next.data[c] = wr_val[`DUC_DW-1:0];
            if (!st_reg.sync[c]) begin
              st_next.latch[c] = wr_val[`DUC_DW-1:0];
              st_next.pend[c]  = 1'b0;
            end else begin
              st_next.pend[c]  = 1'b1;
            end
          end
          if (wr_addr == `DUC_OFF_CLRV0 + `DUC_AW'(4 * c))
            st_next.clrval[c] = wr_val[`DUC_DW-1:0];
        end
        case (wr_addr)
          `DUC_OFF_SYNC:   st_next.sync  = wr_val[`DUC_NCH-1:0];
          `DUC_OFF_CLEAR:  st_next.clr   = wr_val[`DUC_NCH-1:0];
          `DUC_OFF_CONFIG: trig = wr_val[`DUC_LOAD_BIT];
          `DUC_OFF_POWER:  st_next.power = wr_val[`DUC_PW-1:0];
          `DUC_OFF_GDIR:   st_next.gdir  = wr_val[`DUC_NGP-1:0];
          `DUC_OFF_GOUT:   st_next.gout  = wr_val[`DUC_NGP-1:0];
          // any other value of the key register does nothing
          `DUC_OFF_RESET:  soft_rst = (wr_val[15:0] == `DUC_RESET_KEY);
          default: ;
        endcase
      end
    end
    if (st_reg.wst == DUC_WR_RESP && s_axi_bready) begin
      st_next.wst = DUC_WR_IDLE;
    end
    // read: one word answered the cycle after the address is taken
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rst   = DUC_RD_RESP;
      st_next.rdata = '0;
      st_next.rresp = `DUC_RESP_SLVERR;
      // status stays readable so software may poll the lockout
      if (is_mapped(s_axi_araddr) &&
          (!busy || s_axi_araddr == `DUC_OFF_STATUS)) begin
        st_next.rdata = reg_read(st_reg, s_axi_araddr, busy);
        st_next.rresp = `DUC_RESP_OKAY;
      end
    end else if (st_reg.rst == DUC_RD_RESP && s_axi_rready) begin
      st_next.rst = DUC_RD_IDLE;
    end
    // load trigger moves only channels written since the last one
    for (int c = 0; c < `DUC_NCH; c++) begin
      if (trig && st_reg.pend[c]) begin
        st_next.latch[c] = st_reg.data[c];
        st_next.pend[c]  = 1'b0;
      end
    end
    // input pins are sampled every cycle, driven pins hold the last sample
    for (int i = 0; i < `DUC_NGP; i++) begin
      if (!st_reg.gdir[i]) st_next.gin[i] = general_purpose_pin_i[i];
    end
    // key accepted: every register returns to its default
    if (soft_rst) begin
      st_next.data   = '0;
      st_next.latch  = '0;
      st_next.clrval = '0;
      st_next.pend   = '0;
      st_next.sync   = '0;
      st_next.clr    = '0;
      st_next.power  = `DUC_POWER_RST;
      st_next.gdir   = '0;
      st_next.gout   = '0;
      st_next.gin    = '0;
    end
    // output code follows latch or preset in the same edge
    for (int c = 0; c < `DUC_NCH; c++) begin
      st_next.dac_out[c] = st_next.clr[c] ? st_next.clrval[c]
                                          : st_next.latch[c];
    end
    st_next.awready = !st_next.aw_have && st_next.wst == DUC_WR_IDLE;
    st_next.wready  = !st_next.w_have && st_next.wst == DUC_WR_IDLE;
    st_next.arready = st_next.rst == DUC_RD_IDLE;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-up defaults equal the soft reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= '0;
      st_reg.wst   <= DUC_WR_IDLE;
      st_reg.rst   <= DUC_RD_IDLE;
      st_reg.power <= `DUC_POWER_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign s_axi_awready          = st_reg.awready;
  assign s_axi_wready           = st_reg.wready;
  assign s_axi_bvalid           = st_reg.wst == DUC_WR_RESP;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = st_reg.arready;
  assign s_axi_rvalid           = st_reg.rst == DUC_RD_RESP;
  assign s_axi_rdata            = st_reg.rdata;
  assign s_axi_rresp            = st_reg.rresp;
  assign channel_analog_output  = st_reg.dac_out;
  assign power_ctrl             = st_reg.power;
  assign general_purpose_pin_o  = st_reg.gout;
  assign general_purpose_pin_oe = st_reg.gdir;
  assign lockout_busy           = busy;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic wr_d0;    // full write to channel 0 data
  logic wr_clr;   // write to the clear register
  logic wr_key;   // write to the key register
  assign wr_d0  = ce && wr_go && !busy && wr_addr == `DUC_OFF_DATA0;
  assign wr_clr = ce && wr_go && !busy && wr_addr == `DUC_OFF_CLEAR;
  assign wr_key = ce && wr_go && !busy && wr_addr == `DUC_OFF_RESET;

  async_write_a: assert property (wr_d0 && !st_reg.sync[0] |=>
      st_reg.latch[0] == $past(wr_val[`DUC_DW-1:0]) &&
      channel_analog_output[0] == ($past(st_next.clr[0]) ?
        st_reg.clrval[0] : st_reg.latch[0]))
    else $error("async write did not reach latch");
  load_copy_a: assert property (ce && trig && st_reg.pend[0] |=>
      st_reg.latch[0] == $past(st_reg.data[0]) && !st_reg.pend[0])
    else $error("load trigger did not copy pending channel");
  load_skip_a: assert property (ce && trig && !st_reg.pend[0] |=>
      $stable(st_reg.latch[0]))
    else $error("unwritten channel was reloaded");
  latch_out_a: assert property (ce && !st_reg.clr[0] &&
      st_next.latch[0] != st_reg.latch[0] && !st_next.clr[0] |=>
      channel_analog_output[0] == st_reg.latch[0])
    else $error("output lags latch");
  clear_out_a: assert property (wr_clr && wr_val[0] |=>
      channel_analog_output[0] == st_reg.clrval[0])
    else $error("clear did not drive preset");
  clear_keep_a: assert property (wr_clr && wr_val[0] |=>
      st_reg.data[0] == $past(st_reg.data[0]))
    else $error("clear changed data register");
  unclear_out_a: assert property (wr_clr && !wr_val[0] |=>
      channel_analog_output[0] == st_reg.latch[0])
    else $error("leaving clear did not restore latch");
  // a soft reset clears the captured levels, so that cycle is left out
  pin_sample_a: assert property (ce && !soft_rst &&
      !general_purpose_pin_oe[0] |=>
      st_reg.gin[0] == $past(general_purpose_pin_i[0]))
    else $error("input pin level not captured");
  soft_reset_a: assert property (soft_rst && ce |=>
      general_purpose_pin_oe == '0 && power_ctrl == `DUC_POWER_RST &&
      lockout_busy ##1 lockout_busy)
    else $error("software reset did not restore defaults");
  bad_key_a: assert property (wr_key &&
      wr_val[15:0] != `DUC_RESET_KEY |=> !lockout_busy &&
      $stable(st_reg.gdir) && $stable(st_reg.latch))
    else $error("wrong key changed state");

  cover property (ce && trig && st_reg.pend != '0);
  cover property (ce && soft_rst);
  cover property (wr_clr && wr_val[0]);
  cover property (wr_d0 && st_reg.sync[0]);
endmodule : duc_top

// *** duc_pin_model.sv ***
// far-side model of the twelve general-purpose pins and their wiring
`timescale 1ns/1ps
module duc_pin_model (
  // core side
  input  wire logic [11:0] pin_o,
  input  wire logic [11:0] pin_oe,
  // outside world
  input  wire logic [11:0] ext_level,
  output logic [11:0]      pin_level
);
  // a pin the core drives shows the core level, the rest the outside level
  assign pin_level = (pin_oe & pin_o) | (~pin_oe & ext_level);
endmodule : duc_pin_model

// *** test_dac_update_gpio_reset_control.sv ***
// self-checking bench for the converter control core
`timescale 1ns/1ps
`include "duc_consts.svh"
module test_dac_update_gpio_reset_control;
  import duc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic             aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]       awaddr = 0, araddr = 0;
  logic             awvalid = 0, wvalid = 0, bready = 0;
  logic             arvalid = 0, rready = 0;
  logic [31:0]      wdata = 0, rdata;
  logic [3:0]       wstrb = 4'hf;
  logic             awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]       bresp, rresp;
  duc_code_t [3:0]  dac;
  logic [15:0]      power;
  logic [11:0]      pin_i, pin_o, pin_oe, ext = 12'ha5c;
  int               num_errors = 0, num_checks = 0;
  // 5 ns clock
  always #2.5 aclk = ~aclk;
  // short lockout keeps the run brief
  duc_top #(.LOCK_CYCLES(20)) DUT (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .channel_analog_output(dac), .power_ctrl(power),
    .general_purpose_pin_i(pin_i), .general_purpose_pin_o(pin_o),
    .general_purpose_pin_oe(pin_oe), .lockout_busy(busy));
  duc_pin_model pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_level(ext),
    .pin_level(pin_i));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one write; address and data held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    // bready stays high, so a following write never retoggles it
    chk(bresp, er);
  endtask : wr
  // one read, data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    // rready stays high, so a following read never retoggles it
    chk(rdata, ed);
    chk(rresp, er);
  endtask : rd
  // the host stays quiet while the lockout runs
  task automatic wait_free;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge aclk);
  endtask : wait_free
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // watchdog and tests
  // ****************************************************************
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge aclk);
    chk(pin_oe, 0);
    chk(power, 0);
    aresetn <= 1;
    rd(`DUC_OFF_STATUS, 1, `DUC_RESP_OKAY);
    wr(`DUC_OFF_DATA0, 32'h0000_03ff, `DUC_RESP_SLVERR);
    wait_free;
    // asynchronous channel 0 follows its write at once
    wr(`DUC_OFF_DATA0, 32'h0000_0155, `DUC_RESP_OKAY);
    chk(dac[0], 10'h155);
    rd(`DUC_OFF_DATA0, 32'h0000_0155, `DUC_RESP_OKAY);
    // channels 1 and 2 wait for the load bit
    wr(`DUC_OFF_SYNC, 32'h0000_0006, `DUC_RESP_OKAY);
    wr(`DUC_OFF_DATA0 + 8'h04, 32'h0000_00aa, `DUC_RESP_OKAY);
    wr(`DUC_OFF_DATA0 + 8'h08, 32'h0000_0033, `DUC_RESP_OKAY);
    chk(dac[1], 0);
    rd(`DUC_OFF_DATA0 + 8'h04, 0, `DUC_RESP_OKAY);
    wr(`DUC_OFF_CONFIG, 32'h0000_0800, `DUC_RESP_OKAY);
    chk({dac[2], dac[1]}, {10'h033, 10'h0aa});
    chk(dac[3], 0);
    wr(`DUC_OFF_DATA0 + 8'h04, 32'h0000_0111, `DUC_RESP_OKAY);
    wr(`DUC_OFF_CONFIG, 32'h0000_0800, `DUC_RESP_OKAY);
    chk({dac[2], dac[1], dac[0]}, {10'h033, 10'h111, 10'h155});
    // clear to presets and back, with a code pending on channel 1
    wr(`DUC_OFF_DATA0 + 8'h04, 32'h0000_0222, `DUC_RESP_OKAY);
    wr(`DUC_OFF_CLRV0, 32'h0000_03ff, `DUC_RESP_OKAY);
    wr(`DUC_OFF_CLEAR, 32'h0000_0003, `DUC_RESP_OKAY);
    chk({dac[1], dac[0]}, {10'h000, 10'h3ff});
    rd(`DUC_OFF_DATA0, 32'h0000_0155, `DUC_RESP_OKAY);
    wr(`DUC_OFF_CLEAR, 0, `DUC_RESP_OKAY);
    chk({dac[1], dac[0]}, {10'h111, 10'h155});
    // the pending code survived the clear and now loads
    wr(`DUC_OFF_CONFIG, 32'h0000_0800, `DUC_RESP_OKAY);
    chk(dac[1], 10'h222);
    // pins: upper and lower nibbles inputs, middle nibble outputs
    wr(`DUC_OFF_GDIR, 32'h0000_00f0, `DUC_RESP_OKAY);
    wr(`DUC_OFF_GOUT, 32'h0000_0fff, `DUC_RESP_OKAY);
    chk(pin_oe, 12'h0f0);
    chk(pin_i, 12'haf0 | 12'h00c);
    ext <= 12'h3c6;
    repeat (3) @(posedge aclk);
    rd(`DUC_OFF_GIN, 32'h0000_0356, `DUC_RESP_OKAY);
    wr(`DUC_OFF_GOUT, 0, `DUC_RESP_OKAY);
    chk(pin_i, 12'h306);
    rd(`DUC_OFF_STATUS + 8'h04, 0, `DUC_RESP_SLVERR);
    // wrong key leaves all, right key restores defaults
    wr(`DUC_OFF_POWER, 32'h0000_ffff, `DUC_RESP_OKAY);
    wr(`DUC_OFF_RESET, 32'h0000_1234, `DUC_RESP_OKAY);
    chk({busy, power, dac[0]}, {1'b0, 16'hffff, 10'h155});
    wr(`DUC_OFF_RESET, 32'h0000_6600, `DUC_RESP_OKAY);
    chk({busy, power, pin_oe}, {1'b1, 16'h0000, 12'h000});
    chk({dac[3], dac[2]}, 0);
    chk({dac[1], dac[0]}, 0);
    wr(`DUC_OFF_GDIR, 32'h0000_0fff, `DUC_RESP_SLVERR);
    wait_free;
    rd(`DUC_OFF_GDIR, 0, `DUC_RESP_OKAY);
    wrap_up;
  end
endmodule : test_dac_update_gpio_reset_control
